// ### verilog/els_params.svh
// Constants for the execution latency and serialization scheduler
`ifndef ELS_PARAMS_SVH
`define ELS_PARAMS_SVH
`define ELS_LAT_ONE        5'h01
`define ELS_LAT_THREE      5'h03
`define ELS_LAT_FOUR       5'h04
`define ELS_LAT_MULT_EXTRA 5'h02
`define ELS_LAT_WIDTH      5
`define ELS_OP_WIDTH       6
`define ELS_REG_CNT_WIDTH  5
`endif

// ### verilog/els_pkg.sv
// Types for the execution latency and serialization scheduler
package els_pkg;
   typedef enum logic [5:0] {
      ELS_OP_STORE, ELS_OP_STORE_MULT, ELS_OP_MUL_WORD, ELS_OP_MUL_IMM,
      ELS_OP_MF_CR, ELS_OP_MF_MSR, ELS_OP_MF_TB, ELS_OP_MF_XER_CR,
      ELS_OP_MF_SPR_LINK, ELS_OP_MF_SPR_OTHER, ELS_OP_MT_CRF_MULTI,
      ELS_OP_MT_CRF_SINGLE, ELS_OP_MT_LINK, ELS_OP_MT_XER, ELS_OP_MT_MSR,
      ELS_OP_MT_SPR_OTHER, ELS_OP_RFI, ELS_OP_SYSTEM_CALL, ELS_OP_SIMPLE_INT,
      ELS_OP_SUB_CARRY, ELS_OP_FPSCR, ELS_OP_FP_PIPED, ELS_OP_FP_NONPIPED,
      ELS_OP_TLB_INVAL, ELS_OP_STORE_COND, ELS_OP_UNKNOWN
   } els_op_t;

   typedef enum logic [2:0] {
      ELS_UNIT_NONE, ELS_UNIT_SINGLE_CYCLE_INT_UNIT_X, ELS_UNIT_MULTI_CYCLE_INT_UNIT_X, ELS_UNIT_LDST,
      ELS_UNIT_FPU, ELS_UNIT_COMPLETION
   } els_unit_t;

   // One flag per serialization class
   typedef struct packed {
      logic dispatch;
      logic execute;
      logic complete;
      logic postdispatch;
      logic string_mult;
      logic non_piped;
   } els_serial_t;

   typedef struct packed {
      els_op_t   op;
      logic [4:0] reg_cnt;
      logic       early_exit;
      logic [4:0] fp_busy_cycles;
   } els_req_t;

   typedef struct packed {
      els_unit_t   unit;
      logic [4:0]  latency;
      logic        variable_lat;
      els_serial_t serial;
      logic        flush_younger;
   } els_sched_t;
endpackage

// ### verilog/els_decode.sv
// Opcode class to unit, latency and serialization decode
`timescale 1ns/1ps
`include "els_params.svh"
module els_decode
   import els_pkg::*;
(
   input  wire els_req_t   req,
   output els_sched_t      sched
);
   // Pure table lookup; the caller registers the result
   always_comb begin
      sched = '0;
      sched.unit = ELS_UNIT_NONE;
      case (req.op)
         ELS_OP_STORE: begin
            sched.unit = ELS_UNIT_LDST;
            sched.latency = `ELS_LAT_THREE;
            sched.serial.execute = 1'b1;
         end
         ELS_OP_STORE_MULT: begin
            sched.unit = ELS_UNIT_LDST;
            sched.latency = 5'(req.reg_cnt + `ELS_LAT_MULT_EXTRA);
            sched.serial.string_mult = 1'b1;
         end
         ELS_OP_MUL_WORD: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = req.early_exit ? `ELS_LAT_THREE : `ELS_LAT_FOUR;
         end
         ELS_OP_MUL_IMM: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_THREE;
         end
         ELS_OP_MF_CR, ELS_OP_MF_MSR, ELS_OP_MF_TB, ELS_OP_MF_XER_CR,
         ELS_OP_MF_SPR_LINK, ELS_OP_MF_SPR_OTHER: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_THREE;
            sched.serial.execute = 1'b1;
         end
         ELS_OP_MT_CRF_MULTI: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
            sched.serial.dispatch = 1'b1;
            sched.serial.execute = 1'b1;
         end
         ELS_OP_MT_CRF_SINGLE: begin
            sched.unit = ELS_UNIT_SINGLE_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
         end
         ELS_OP_MT_LINK: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
            sched.serial.dispatch = 1'b1;
         end
         ELS_OP_MT_XER: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
            sched.serial.complete = 1'b1;
            sched.flush_younger = 1'b1;
         end
         ELS_OP_MT_MSR, ELS_OP_MT_SPR_OTHER: begin
            sched.unit = ELS_UNIT_MULTI_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
            sched.serial.execute = 1'b1;
         end
         ELS_OP_RFI, ELS_OP_SYSTEM_CALL: begin
            sched.unit = ELS_UNIT_COMPLETION;
            sched.serial.postdispatch = 1'b1;
            sched.variable_lat = 1'b1;
         end
         ELS_OP_SIMPLE_INT: begin
            sched.unit = ELS_UNIT_SINGLE_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
         end
         ELS_OP_SUB_CARRY: begin
            sched.unit = ELS_UNIT_SINGLE_CYCLE_INT_UNIT_X;
            sched.latency = `ELS_LAT_ONE;
            sched.serial.execute = 1'b1;
         end
         ELS_OP_FPSCR, ELS_OP_FP_PIPED: begin
            sched.unit = ELS_UNIT_FPU;
            sched.latency = `ELS_LAT_THREE;
         end
         ELS_OP_FP_NONPIPED: begin
            sched.unit = ELS_UNIT_FPU;
            sched.latency = req.fp_busy_cycles;
            sched.serial.non_piped = 1'b1;
         end
         ELS_OP_TLB_INVAL: begin
            sched.unit = ELS_UNIT_LDST;
            sched.variable_lat = 1'b1;
            sched.serial.execute = 1'b1;
         end
         ELS_OP_STORE_COND: begin
            sched.unit = ELS_UNIT_LDST;
            sched.latency = `ELS_LAT_THREE;
            sched.serial.execute = 1'b1;
         end
         default: begin
            sched.unit = ELS_UNIT_NONE;
         end
      endcase
   end
endmodule

// ### verilog/els_sched.sv
// Execution scheduler: issues classified ops and times their results
//
// Contract
// - Scalar stores go to load/store unit, three cycles, execute-serialized.
// - Store multiple/string take register count plus two, string/multiple serialized.
// - Condition, state, time base, exception reads: three cycles, execute-serialized.
// - Special register reads: three cycles, multi-cycle unit, execute-serialized.
// - Zero/multi field condition write: multi-cycle, one cycle, dispatch and execute.
// - Single field condition write: single-cycle unit, one cycle, unserialized.
// - Link/count writes: one cycle multi-cycle unit, dispatch-serialized.
// - Exception register write: one cycle multi-cycle unit, completion-serialized.
// - Exception register write flushes younger in-flight instructions.
// - State and other special writes: one cycle, execute-serialized.
// - Return-from-interrupt and system call go to completion, postdispatch-serialized.
// - Logical, shift, rotate, negate, subtract-from, trap: one cycle, unserialized.
// - Carry-consuming subtracts: one cycle single-cycle unit, execute-serialized.
// - Non-pipelined float waits for float unit empty and blocks later floats.
// - Translation invalidate: load/store unit, variable latency, execute-serialized.
// - Conditional store word: load/store unit, three cycles, execute-serialized.
`timescale 1ns/1ps
`include "els_params.svh"
module els_sched
   import els_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       issue_valid,
   input  wire els_req_t   issue_req,
   output logic            issue_ready,
   input  wire logic       var_done,
   output els_sched_t      issued_sched,
   output logic            issued_pulse,
   output logic            result_valid,
   output els_unit_t       result_unit,
   output logic            flush_younger,
   output logic            fp_busy,
   output logic            unit_busy
);
   typedef enum {ELS_IDLE, ELS_COUNT, ELS_WAIT_VAR} els_state_t;

   els_sched_t  dec;
   els_state_t  state;
   logic [4:0]  remain;
   logic [4:0]  fp_remain;
   logic        take;
   logic        fp_block;
   logic        is_fp;
   logic        int_done;
   logic [2:0]  fp_stage;

   ////////////////////////////////////////////////////////////////
   els_decode u_decode (
      .req   (issue_req),
      .sched (dec)
   );

   assign is_fp       = (dec.unit == ELS_UNIT_FPU);
   assign fp_block    = is_fp && (fp_remain != 5'h00) &&
                        (dec.serial.non_piped || fp_busy);
   // Serialized: one tracked op at a time keeps serialization simple
   assign issue_ready = (state == ELS_IDLE) && !fp_block;
   assign take        = issue_valid && issue_ready;
   // Non-float op ends this cycle: counted latency or far-side done
   assign int_done    = ((state == ELS_COUNT) && (remain == 5'h01)) ||
                        ((state == ELS_WAIT_VAR) && var_done);

   ////////////////////////////////////////////////////////////////
   // latency counted from entry
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state  <= ELS_IDLE;
         remain <= 5'h00;
      end else begin
         case (state)
            ELS_IDLE: begin
               if (take && dec.variable_lat) begin
                  state <= ELS_WAIT_VAR;
               end else if (take && !is_fp) begin
                  state  <= ELS_COUNT;
                  remain <= dec.latency;
               end
            end
            ELS_COUNT: begin
               remain <= remain - 5'h01;
               if (remain == 5'h01) begin
                  state <= ELS_IDLE;
               end
            end
            ELS_WAIT_VAR: begin
               if (var_done) begin
                  state <= ELS_IDLE;
               end
            end
            default: begin
               state <= ELS_IDLE;
            end
         endcase
      end
   end

   // Float ops pipeline freely; only non-pipelined ones hold the unit
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fp_remain <= 5'h00;
         fp_busy   <= 1'b0;
      end else if (take && is_fp) begin
         fp_remain <= dec.latency;
         fp_busy   <= dec.serial.non_piped;
      end else if (fp_remain != 5'h00) begin
         fp_remain <= fp_remain - 5'h01;
         if (fp_remain == 5'h01) begin
            fp_busy <= 1'b0;
         end
      end
   end

   // one bit per pipelined float stage
   // A single down-counter would lose the older result when floats overlap
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fp_stage <= 3'h0;
      end else begin
         fp_stage <= {fp_stage[1:0], take && is_fp && !dec.serial.non_piped};
      end
   end

   // Result strobe and registered issue record
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         issued_sched  <= '0;
         issued_pulse  <= 1'b0;
         result_valid  <= 1'b0;
         result_unit   <= ELS_UNIT_NONE;
         flush_younger <= 1'b0;
      end else begin
         issued_pulse <= take;
         if (take) begin
            issued_sched <= dec;
         end
         flush_younger <= take && dec.flush_younger;
         result_valid  <= int_done || fp_stage[2] || (fp_busy && (fp_remain == 5'h01));
         // Non-float result wins a shared cycle; otherwise the float unit reports
         if (int_done) begin
            result_unit <= issued_sched.unit;
         end else begin
            result_unit <= ELS_UNIT_FPU;
         end
      end
   end

   assign unit_busy = (state != ELS_IDLE);
endmodule

// ### testbench/els_checker.sv
// Port assertions for the execution scheduler
`timescale 1ns/1ps
module els_checker
   import els_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       issue_valid,
   input wire els_req_t   issue_req,
   input wire logic       issue_ready,
   input wire logic       var_done,
   input wire els_sched_t issued_sched,
   input wire logic       issued_pulse,
   input wire logic       result_valid,
   input wire els_unit_t  result_unit,
   input wire logic       flush_younger,
   input wire logic       fp_busy,
   input wire logic       unit_busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Take strobe and shorthands
   wire        tk = issue_valid && issue_ready;
   els_op_t    op;
   els_sched_t s;
   assign op = issue_req.op;
   assign s = issued_sched;
   property p_st;
      tk && op == ELS_OP_STORE |=> issued_pulse && s.serial.execute
         && s.unit == ELS_UNIT_LDST ##0 !result_valid [*3] ##1 result_valid;
   endproperty
   a_st: assert property (p_st) else $error("store timing");
   property p_sm;
      tk && op == ELS_OP_STORE_MULT |=> s.serial.string_mult
         && s.latency == $past(issue_req.reg_cnt) + 5'h02;
   endproperty
   a_sm: assert property (p_sm) else $error("multiple store");
   property p_mw;
      tk && op == ELS_OP_MUL_WORD |=> s.serial == '0
         && s.latency == ($past(issue_req.early_exit) ? 5'h03 : 5'h04);
   endproperty
   a_mw: assert property (p_mw) else $error("word multiply");
   property p_mi;
      tk && op == ELS_OP_MUL_IMM |=> s.serial == '0 ##0 !result_valid [*3] ##1 result_valid;
   endproperty
   a_mi: assert property (p_mi) else $error("immediate multiply");
   property p_rd;
      tk && op inside {ELS_OP_MF_CR, ELS_OP_MF_MSR, ELS_OP_MF_TB, ELS_OP_MF_SPR_OTHER,
                       ELS_OP_MF_XER_CR, ELS_OP_MF_SPR_LINK}
         |=> s.latency == 5'h03 && s.serial.execute;
   endproperty
   a_rd: assert property (p_rd) else $error("register read");
   property p_ub;
      tk && op == ELS_OP_SIMPLE_INT |=> unit_busy ##1 !unit_busy;
   endproperty
   a_ub: assert property (p_ub) else $error("single cycle occupancy");
   property p_c1;
      tk && op == ELS_OP_MT_CRF_SINGLE |=> s.serial == '0 ##0 !result_valid ##1 result_valid;
   endproperty
   a_c1: assert property (p_c1) else $error("single field write");
   property p_xr;
      tk && op == ELS_OP_MT_XER |=> flush_younger && s.serial.complete;
   endproperty
   a_xr: assert property (p_xr) else $error("exception write");
   property p_po;
      tk && op inside {ELS_OP_RFI, ELS_OP_SYSTEM_CALL}
         |=> s.unit == ELS_UNIT_COMPLETION && s.serial.postdispatch;
   endproperty
   a_po: assert property (p_po) else $error("completion op");
   property p_fp;
      fp_busy && issue_valid && op inside {ELS_OP_FP_PIPED, ELS_OP_FP_NONPIPED} |-> !issue_ready;
   endproperty
   a_fp: assert property (p_fp) else $error("float not held");
   c_sm: cover property (tk && op == ELS_OP_STORE_MULT);
   c_fp: cover property (fp_busy && issue_valid);
   c_vd: cover property (var_done ##[1:2] result_valid);
endmodule
bind els_sched els_checker u_chk (.sys_clk, .rst, .issue_valid, .issue_req, .issue_ready,
   .var_done, .issued_sched, .issued_pulse, .result_valid, .result_unit, .flush_younger,
   .fp_busy, .unit_busy);

// ### testbench/els_completion_model.sv
// Completion side: ends variable-latency ops after a set delay
`timescale 1ns/1ps
module els_completion_model
   import els_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       issued_pulse,
   input  wire els_sched_t issued_sched,
   input  wire logic [3:0] delay,
   output logic            var_done
);
   logic [3:0] remain;
   // unlisted latency ends here; delay zero would never end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         remain <= 4'h0;
         var_done <= 1'b0;
      end else begin
         var_done <= (remain == 4'h1);
         if (issued_pulse && issued_sched.variable_lat)
            remain <= delay;
         else if (remain != 4'h0)
            remain <= remain - 4'h1;
      end
   end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the execution scheduler
`timescale 1ns/1ps
module tb_top;
   import els_pkg::*;
   localparam els_unit_t u_one = els_unit_t'(3'h1);
   localparam els_unit_t u_mc = els_unit_t'(3'h2);
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       issue_valid = 1'b0;
   els_req_t   issue_req = '0;
   logic [3:0] delay = 4'h2;
   logic       var_done, issue_ready, issued_pulse, result_valid, flush_younger, fp_busy;
   els_sched_t issued_sched;
   els_unit_t  result_unit;
   int         errors = 0;
   int         total_checks = 0;
   always #10 sys_clk = ~sys_clk;
   els_sched u_dut (.sys_clk, .rst, .issue_valid, .issue_req, .issue_ready, .var_done,
      .issued_sched, .issued_pulse, .result_valid, .result_unit, .flush_younger,
      .fp_busy, .unit_busy());
   els_completion_model u_far (.sys_clk, .rst, .issued_pulse, .issued_sched, .delay,
      .var_done);
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // Hold the request until an edge with ready high takes it
   task automatic issue(input els_op_t op, input logic [4:0] cnt, input logic ee,
                        input logic [4:0] fpc);
      int n = 0;
      @(posedge sys_clk);
      issue_valid <= 1'b1;
      issue_req <= '{op, cnt, ee, fpc};
      @(negedge sys_clk);
      while (issue_ready !== 1'b1 && n < 99) begin
         n++;
         @(negedge sys_clk);
      end
      if (n == 99) begin
         check(1'b0, "never taken");
         report_and_stop();
      end
      @(posedge sys_clk);
      issue_valid <= 1'b0;
   endtask
   // Cycles from the take edge until the result shows
   task automatic wait_res(output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (result_valid !== 1'b1 && n < 60);
      if (n == 60) begin
         check(1'b0, "no result");
         report_and_stop();
      end
   endtask
   task automatic do_op(input els_op_t op, input logic [4:0] cnt, input logic ee,
                        input int lat, input els_unit_t unit);
      int n;
      issue(op, cnt, ee, 5'h00);
      wait_res(n);
      // Result shows in the cycle after the last unit cycle
      check(n == lat + 1 && result_unit === unit, "latency or unit");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_store;
      do_op(ELS_OP_STORE, 5'h00, 1'b0, 3, ELS_UNIT_LDST);
      do_op(ELS_OP_STORE_COND, 5'h00, 1'b0, 3, ELS_UNIT_LDST);
      do_op(ELS_OP_STORE_MULT, 5'h00, 1'b0, 2, ELS_UNIT_LDST);
      do_op(ELS_OP_STORE_MULT, 5'h1d, 1'b0, 31, ELS_UNIT_LDST);
   endtask
   task automatic t_mul;
      do_op(ELS_OP_MUL_WORD, 5'h00, 1'b0, 4, u_mc);
      do_op(ELS_OP_MUL_WORD, 5'h00, 1'b1, 3, u_mc);
      do_op(ELS_OP_MUL_IMM, 5'h00, 1'b0, 3, u_mc);
   endtask
   // Reads take three cycles, writes one
   task automatic t_regs;
      els_op_t rd[6] = '{ELS_OP_MF_CR, ELS_OP_MF_MSR, ELS_OP_MF_TB, ELS_OP_MF_SPR_LINK,
                         ELS_OP_MF_SPR_OTHER, ELS_OP_MF_XER_CR};
      els_op_t wr[5] = '{ELS_OP_MT_CRF_MULTI, ELS_OP_MT_LINK, ELS_OP_MT_XER, ELS_OP_MT_MSR,
                         ELS_OP_MT_SPR_OTHER};
      els_op_t sc[3] = '{ELS_OP_MT_CRF_SINGLE, ELS_OP_SIMPLE_INT, ELS_OP_SUB_CARRY};
      foreach (rd[i])
         do_op(rd[i], 5'h00, 1'b0, 3, u_mc);
      foreach (wr[i])
         do_op(wr[i], 5'h00, 1'b0, 1, u_mc);
      foreach (sc[i])
         do_op(sc[i], 5'h00, 1'b0, 1, u_one);
   endtask
   // Variable ops finish only after the far side says so
   task automatic t_var;
      els_op_t v[3] = '{ELS_OP_TLB_INVAL, ELS_OP_RFI, ELS_OP_SYSTEM_CALL};
      int n;
      foreach (v[i]) begin
         delay <= 4'h2 + 4'(i * 3);
         issue(v[i], 5'h00, 1'b0, 5'h00);
         wait_res(n);
         check(n >= 5 + i * 3 && n <= 6 + i * 3, "variable end");
         check(result_unit === (i == 0 ? ELS_UNIT_LDST : ELS_UNIT_COMPLETION), "unit");
      end
   endtask
   // Non-pipelined float holds the unit; pipelined ones overlap
   task automatic t_fp;
      int  n;
      time t0;
      do_op(ELS_OP_FPSCR, 5'h00, 1'b0, 3, ELS_UNIT_FPU);
      issue(ELS_OP_FP_NONPIPED, 5'h00, 1'b0, 5'h03);
      wait_res(n);
      check(n == 4 && result_unit === ELS_UNIT_FPU, "non-pipelined float");
      issue(ELS_OP_FP_NONPIPED, 5'h00, 1'b0, 5'h06);
      t0 = $time;
      @(negedge sys_clk);
      check(fp_busy === 1'b1, "float unit not held");
      issue(ELS_OP_FP_PIPED, 5'h00, 1'b0, 5'h00);
      // Unit frees the edge after the six busy cycles
      check(($time - t0) == 7 * 20, "float started early");
      wait_res(n);
      check(n == 4 && result_unit === ELS_UNIT_FPU, "pipelined float");
      // Second op is taken two edges after the first, so results come two apart
      issue(ELS_OP_FP_PIPED, 5'h00, 1'b0, 5'h00);
      issue(ELS_OP_FP_PIPED, 5'h00, 1'b0, 5'h00);
      wait_res(n);
      check(n == 2 && result_unit === ELS_UNIT_FPU, "first overlapped float");
      wait_res(n);
      check(n == 2 && result_unit === ELS_UNIT_FPU, "second overlapped float");
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_store();
      t_mul();
      t_regs();
      t_var();
      t_fp();
      report_and_stop();
   end
endmodule
